/* hdl/hwmon_status.sv */
// fan, diode and supply status flags behind an avalon-mm slave
`timescale 1ns/10ps
module hwmon_status
   import hwmon_status_pkg::*;
#(
   parameter int fans = 4
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // tachometer front end
   input wire logic [fans*16-1:0] tach_count,
   input wire logic [fans-1:0] tach_update,
   // diode front end
   input wire logic [1:0] diode_fault,
   input wire logic [1:0] diode_update,
   input wire logic [15:0] diode_temp,
   // supply front end
   input wire logic [7:0] core_reading,
   input wire logic [7:0] main_reading,
   input wire logic supply_update,
   // outputs
   output logic monitor_start,
   output logic irq
);
   logic [7:0] fan_diode_event_flags;
   logic [fans-1:0] fan_flags;
   logic [1:0] diode_flags;
   logic [7:0] core_supply_low_limit;
   logic [7:0] core_supply_high_limit;
   logic [7:0] main_supply_low_limit;
   logic [7:0] main_supply_high_limit;
   logic [15:0] tach_min [fans];
   logic [7:0] ctrl;
   logic [7:0] enables;
   logic [1:0] diode_limit_err;
   logic [7:0] diode_reading [2];
   logic [irq_width-1:0] irq_status;
   logic [irq_width-1:0] irq_mask;
   logic core_flag;
   logic main_flag;
   logic started;
   logic wr_go;
   logic rd_go;
   logic rd_events;
   logic rd_first;
   logic [7:0] wbyte;
   logic [7:0] first_status;
   logic [7:0] next_rdata;
   logic [7:0] prev_events;
   logic [1:0] prev_supply;
   logic busy;

   // ------------------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------------------
   // one wait cycle, then the access completes; waitrequest is its own flop
   always_ff @(posedge core_clk) begin
      if (srst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end
   assign busy = !waitrequest;
   assign wr_go = write && busy;
   assign rd_go = read && busy;
   assign wbyte = byteenable[0] ? writedata[7:0] : 8'h00;
   assign rd_events = rd_go && (address == event_flags_addr);
   assign rd_first = rd_go && (address == first_status_addr);
   assign started = ctrl[start_bit];

   // first status register view
   always_comb begin
      first_status = 8'h00;
      first_status[summary_bit] = |fan_diode_event_flags;
      first_status[core_flag_bit] = core_flag;
      first_status[main_flag_bit] = main_flag;
      first_status[diode1_err_bit] = diode_limit_err[0];
      first_status[diode2_err_bit] = diode_limit_err[1];
   end

   // read mux
   always_comb begin
      unique case (address)
         first_status_addr: next_rdata = first_status;
         event_flags_addr: next_rdata = fan_diode_event_flags;
         core_low_addr: next_rdata = core_supply_low_limit;
         core_high_addr: next_rdata = core_supply_high_limit;
         main_low_addr: next_rdata = main_supply_low_limit;
         main_high_addr: next_rdata = main_supply_high_limit;
         control_addr: next_rdata = ctrl;
         enable_addr: next_rdata = enables;
         irq_status_addr: next_rdata = {6'h00, irq_status};
         irq_mask_addr: next_rdata = {6'h00, irq_mask};
         diode1_temp_addr: next_rdata = diode_reading[0];
         diode2_temp_addr: next_rdata = diode_reading[1];
         default: next_rdata = read_data_unmapped;
      endcase
      for (int i = 0; i < fans; i++) begin
         if (address == tach_min_base_addr + 8'(2*i)) next_rdata = tach_min[i][7:0];
         if (address == tach_min_base_addr + 8'(2*i+1)) next_rdata = tach_min[i][15:8];
      end
   end

   // registered read data
   always_ff @(posedge core_clk) begin
      if (srst) begin
         readdata <= 32'h0000_0000;
      end else if (read && !busy) begin
         readdata <= {24'h000000, next_rdata};
      end
   end

   // supply limits, no lock gating here
   always_ff @(posedge core_clk) begin
      if (srst) begin
         core_supply_low_limit <= low_limit_reset;
         core_supply_high_limit <= high_limit_reset;
         main_supply_low_limit <= low_limit_reset;
         main_supply_high_limit <= high_limit_reset;
      end else if (wr_go && byteenable[0]) begin
         if (address == core_low_addr) core_supply_low_limit <= wbyte;
         if (address == core_high_addr) core_supply_high_limit <= wbyte;
         if (address == main_low_addr) main_supply_low_limit <= wbyte;
         if (address == main_high_addr) main_supply_high_limit <= wbyte;
      end
   end

   // control, enables and mask
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl <= 8'h00;
         enables <= enable_reset;
         irq_mask <= '0;
      end else if (wr_go && byteenable[0]) begin
         if (address == control_addr) ctrl <= wbyte;
         if (address == enable_addr) enables <= wbyte;
         if (address == irq_mask_addr) irq_mask <= wbyte[irq_width-1:0];
      end
   end
   assign monitor_start = ctrl[start_bit];

   // tach minimums as byte pairs
   genvar g;
   generate
      for (g = 0; g < fans; g++) begin : g_tach_min
         always_ff @(posedge core_clk) begin
            if (srst) begin
               tach_min[g] <= tach_min_reset;
            end else if (wr_go && byteenable[0]) begin
               if (address == tach_min_base_addr + 8'(2*g)) tach_min[g][7:0] <= wbyte;
               if (address == tach_min_base_addr + 8'(2*g+1)) tach_min[g][15:8] <= wbyte;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------------
   // fan flags, bits 2..5; writes never touch the flags
   // ------------------------------------------------------------------------
   generate
      for (g = 0; g < fans; g++) begin : g_fan
         logic slow;
         logic en;
         assign slow = tach_count[g*16 +: 16] > tach_min[g];
         assign en = enables[fan_flag_lsb+g];
         always_ff @(posedge core_clk) begin
            if (srst) begin
               fan_flags[g] <= 1'b0;
            end else if (started && tach_update[g] && en && slow) begin
               fan_flags[g] <= 1'b1;
            end else if (started && tach_update[g] && !en) begin
               fan_flags[g] <= 1'b0;
            end else if (rd_events && !(started && slow && en)) begin
               fan_flags[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // reserved bits tied low, no write path into the flags
   assign fan_diode_event_flags = {diode_flags, fan_flags, 2'b00};

   // ------------------------------------------------------------------------
   // diode fault flags, readings and limit errors
   // ------------------------------------------------------------------------
   generate
      for (g = 0; g < 2; g++) begin : g_diode
         localparam int fbit = diode1_flag_bit + g;
         logic en;
         assign en = enables[fbit];
         // fault flag: survives read while fault present and monitoring started
         always_ff @(posedge core_clk) begin
            if (srst) begin
               diode_flags[g] <= 1'b0;
            end else if (!en) begin
               diode_flags[g] <= 1'b0;
            end else if (started && diode_fault[g]) begin
               diode_flags[g] <= 1'b1;
            end else if (rd_events) begin
               diode_flags[g] <= 1'b0;
            end
         end
         // reading forced to fault code while running
         always_ff @(posedge core_clk) begin
            if (srst) begin
               diode_reading[g] <= 8'h00;
            end else if (started && diode_fault[g]) begin
               diode_reading[g] <= diode_fault_code;
            end else if (started && diode_update[g]) begin
               diode_reading[g] <= diode_temp[g*8 +: 8];
            end
         end
         // limit error set directly by a running fault, not from the reading
         always_ff @(posedge core_clk) begin
            if (srst) begin
               diode_limit_err[g] <= 1'b0;
            end else if (!en) begin
               diode_limit_err[g] <= 1'b0;
            end else if (started && diode_fault[g]) begin
               diode_limit_err[g] <= 1'b1;
            end else if (rd_first) begin
               diode_limit_err[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------------
   // supply window checks
   // ------------------------------------------------------------------------
   supply_window_check #(.width(8)) u_core (
      .core_clk(core_clk),
      .srst(srst),
      .update(supply_update),
      .reading(core_reading),
      .low_limit(core_supply_low_limit),
      .high_limit(core_supply_high_limit),
      .enable(enables[core_flag_bit]),
      .started(started),
      .read_clear(rd_first),
      .flag(core_flag)
   );
   supply_window_check #(.width(8)) u_main (
      .core_clk(core_clk),
      .srst(srst),
      .update(supply_update),
      .reading(main_reading),
      .low_limit(main_supply_low_limit),
      .high_limit(main_supply_high_limit),
      .enable(enables[main_flag_bit]),
      .started(started),
      .read_clear(rd_first),
      .flag(main_flag)
   );

   // ------------------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------------------
   // rising edges of flag groups set sticky bits, write one clears, set wins
   always_ff @(posedge core_clk) begin
      if (srst) begin
         prev_events <= 8'h00;
         prev_supply <= 2'b00;
         irq_status <= '0;
         irq <= 1'b0;
      end else begin
         prev_events <= fan_diode_event_flags;
         prev_supply <= {main_flag, core_flag};
         for (int i = 0; i < irq_width; i++) begin
            if (wr_go && byteenable[0] && address == irq_status_addr && wbyte[i]) irq_status[i] <= 1'b0;
         end
         if (|(fan_diode_event_flags & ~prev_events)) irq_status[irq_event_bit] <= 1'b1;
         if (|({main_flag, core_flag} & ~prev_supply)) irq_status[irq_supply_bit] <= 1'b1;
         irq <= |(irq_status & irq_mask);
      end
   end

   // ------------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------------
   // flag register: writes, reads and enables
   AST_EVENT_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (srst)
      wr_go && address == event_flags_addr && !started |=> fan_diode_event_flags == $past(fan_diode_event_flags))
      else $error("event flags changed by write");
   AST_READ_CLEARS_FAN: assert property (@(posedge core_clk) disable iff (srst)
      rd_events && !(started && enables[fan_flag_lsb] && tach_count[15:0] > tach_min[0]) |=> !fan_flags[0])
      else $error("fan flag survived read");
   AST_DIODE_SETS: assert property (@(posedge core_clk) disable iff (srst)
      started && diode_fault[1] && enables[diode2_flag_bit] |=> fan_diode_event_flags[diode2_flag_bit])
      else $error("diode fault flag not set");
   AST_FAN_STOPPED_HOLD: assert property (@(posedge core_clk) disable iff (srst)
      !started && !rd_events && fan_flags[0] |=> fan_flags[0])
      else $error("fan flag lost while stopped");
   AST_DIODE_HOLD: assert property (@(posedge core_clk) disable iff (srst)
      rd_events && started && diode_fault[0] && enables[6] |=> fan_diode_event_flags[6])
      else $error("diode flag cleared during fault");
   AST_DIODE_LOAD: assert property (@(posedge core_clk) disable iff (srst)
      started && diode_fault[1] |=> diode_reading[1] == diode_fault_code && diode_limit_err[1] == $past(enables[7]))
      else $error("diode fault code not loaded");
   AST_DIODE_DISABLE: assert property (@(posedge core_clk) disable iff (srst)
      !enables[6] |=> !fan_diode_event_flags[6] && !diode_limit_err[0])
      else $error("disabled diode flags set");
   AST_FAN_OFF_NO_RISE: assert property (@(posedge core_clk) disable iff (srst)
      !enables[fan_flag_lsb] && !fan_flags[0] |=> !fan_flags[0])
      else $error("disabled fan flag rose");
   AST_FAN_DISABLE_UPDATE: assert property (@(posedge core_clk) disable iff (srst)
      started && tach_update[0] && !enables[fan_flag_lsb] |=> !fan_flags[0])
      else $error("disabled fan flag kept at update");
   AST_LIMIT_WRITE: assert property (@(posedge core_clk) disable iff (srst)
      wr_go && byteenable[0] && address == main_high_addr |=> main_supply_high_limit == $past(writedata[7:0]))
      else $error("supply limit write lost");
   AST_SUMMARY: assert property (@(posedge core_clk) disable iff (srst)
      first_status[summary_bit] == (fan_diode_event_flags != 8'h00))
      else $error("summary bit wrong");
   AST_STOPPED_NO_SET: assert property (@(posedge core_clk) disable iff (srst)
      !started && fan_diode_event_flags == 8'h00 |=> fan_diode_event_flags == 8'h00)
      else $error("flag set while stopped");
   AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (srst)
      rd_events ##1 1'b1 |-> readdata[1:0] == 2'b00)
      else $error("reserved bits nonzero");
   // bus timing and interrupt level
   AST_WAIT_ONE: assert property (@(posedge core_clk) disable iff (srst)
      $rose(read) && !busy |=> !waitrequest)
      else $error("read not answered in one cycle");
   AST_WAIT_SINGLE: assert property (@(posedge core_clk) disable iff (srst)
      !waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (srst)
      irq == |($past(irq_status & irq_mask)))
      else $error("interrupt level wrong");

   COV_FAN_SET: cover property (@(posedge core_clk) disable iff (srst) $rose(fan_diode_event_flags[2]));
   COV_DIODE_FAULT: cover property (@(posedge core_clk) disable iff (srst) $rose(diode_limit_err[0]));
   COV_DIODE_HELD: cover property (@(posedge core_clk) disable iff (srst)
      rd_events && started && diode_fault[0] ##1 fan_diode_event_flags[6]);
   COV_SUPPLY: cover property (@(posedge core_clk) disable iff (srst) $rose(core_flag));
   COV_IRQ: cover property (@(posedge core_clk) disable iff (srst) $rose(irq));
endmodule : hwmon_status

/* hdl/hwmon_status_pkg.sv */
// constants for the fan, diode and supply status block
// ----------------------------------------------------------------------------
// Summary of operation
// - event flag register ignores all writes
// - read clears flags whose cause has gone
// - bits 2..5 set when tach exceeds minimum
// - bits 6/7 set on diode short or open
// - set flags hold until read or disable
// - diode flag survives read while fault persists and monitoring is started
// - running diode fault loads 80h, sets limit error
// - diode disable clears fault and limit error
// - disabled flag never rises from zero
// - disabled set fan or supply flag clears at next reading update
// - stopped monitoring delays that clear to the first update after start
// - supply flag on above high or at/below low
// - supply limits writable regardless of lock
// - supply codes: nominal C0h, zero 00h, full FFh
// - summary bit 7 shows any event flag set
// - core supply bit 1, main supply bit 2
// - start bit zero sets no status bit
// ----------------------------------------------------------------------------
package hwmon_status_pkg;
   // register byte addresses
   localparam logic [7:0] first_status_addr = 8'h41;
   localparam logic [7:0] event_flags_addr = 8'h42;
   localparam logic [7:0] core_low_addr = 8'h46;
   localparam logic [7:0] core_high_addr = 8'h47;
   localparam logic [7:0] main_low_addr = 8'h48;
   localparam logic [7:0] main_high_addr = 8'h49;
   localparam logic [7:0] tach_min_base_addr = 8'h54;
   localparam logic [7:0] control_addr = 8'h60;
   localparam logic [7:0] enable_addr = 8'h61;
   localparam logic [7:0] irq_status_addr = 8'h62;
   localparam logic [7:0] irq_mask_addr = 8'h63;
   localparam logic [7:0] diode1_temp_addr = 8'h64;
   localparam logic [7:0] diode2_temp_addr = 8'h65;
   // reset values and fixed codes
   localparam logic [7:0] low_limit_reset = 8'h00;
   localparam logic [7:0] high_limit_reset = 8'hff;
   localparam logic [15:0] tach_min_reset = 16'hffff;
   localparam logic [7:0] enable_reset = 8'hff;
   localparam logic [7:0] diode_fault_code = 8'h80;
   localparam logic [7:0] supply_nominal_code = 8'hc0;
   localparam logic [7:0] read_data_unmapped = 8'h00;
   // field positions
   localparam int fan_flag_lsb = 2;
   localparam int diode1_flag_bit = 6;
   localparam int diode2_flag_bit = 7;
   localparam int core_flag_bit = 1;
   localparam int main_flag_bit = 2;
   localparam int diode1_err_bit = 4;
   localparam int diode2_err_bit = 6;
   localparam int summary_bit = 7;
   localparam int start_bit = 0;
   localparam int lock_bit = 1;
   // interrupt status layout
   localparam int irq_event_bit = 0;
   localparam int irq_supply_bit = 1;
   localparam int irq_width = 2;
endpackage : hwmon_status_pkg

/* hdl/supply_window_check.sv */
// one supply reading against its low and high limits
`timescale 1ns/10ps
module supply_window_check
   import hwmon_status_pkg::*;
#(
   parameter int width = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // reading and limits
   input wire logic update,
   input wire logic [width-1:0] reading,
   input wire logic [width-1:0] low_limit,
   input wire logic [width-1:0] high_limit,
   // flag control
   input wire logic enable,
   input wire logic started,
   input wire logic read_clear,
   output logic flag
);
   logic violate;

   // window compare, low end inclusive
   assign violate = (reading > high_limit) || (reading <= low_limit);

   // sticky flag, set wins over read clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         flag <= 1'b0;
      end else if (started && update && enable && violate) begin
         flag <= 1'b1;
      end else if (started && update && !enable) begin
         flag <= 1'b0;
      end else if (read_clear && !(started && violate)) begin
         flag <= 1'b0;
      end
   end

   AST_SUPPLY_NO_SET_OFF: assert property (@(posedge core_clk) disable iff (srst)
      !flag && !(started && enable) |=> !flag) else $error("supply flag rose while off");
endmodule : supply_window_check

/* sim/front_end_model.sv */
// stimulus model of the tachometer, diode and supply front ends
`timescale 1ns/10ps
module front_end_model (
   // clock
   input wire logic core_clk,
   // tachometer side
   output logic [63:0] tach_count,
   output logic [3:0] tach_update,
   // diode side
   output logic [1:0] diode_fault,
   output logic [1:0] diode_update,
   output logic [15:0] diode_temp,
   // supply side
   output logic [7:0] core_reading,
   output logic [7:0] main_reading,
   output logic supply_update
);
   // ----------------------------------------------------------------
   // idle state: strobes low, readings at nominal
   // ----------------------------------------------------------------
   initial begin
      tach_count = 64'h0;
      tach_update = 4'h0;
      diode_fault = 2'h0;
      diode_update = 2'h0;
      diode_temp = 16'h1919; // plain room-temperature readings
      core_reading = 8'hc0;
      main_reading = 8'hc0;
      supply_update = 1'b0;
   end
   // new count for one fan, with a single update strobe
   task tach(input int i, input logic [15:0] cnt);
      @(posedge core_clk);
      tach_count[16*i +: 16] <= cnt;
      tach_update[i] <= 1'b1;
      @(posedge core_clk);
      tach_update <= 4'h0;
   endtask : tach
   // fault level on one diode pair, with a reading update on the same edge
   task diode(input int j, input logic f);
      @(posedge core_clk);
      diode_fault[j] <= f;
      diode_update[j] <= 1'b1;
      @(posedge core_clk);
      diode_update <= 2'h0;
      repeat (2) @(posedge core_clk);
   endtask : diode
   // both supply readings updated by one strobe
   task supply(input logic [7:0] c, input logic [7:0] m);
      @(posedge core_clk);
      core_reading <= c;
      main_reading <= m;
      supply_update <= 1'b1;
      @(posedge core_clk);
      supply_update <= 1'b0;
   endtask : supply
endmodule : front_end_model

/* sim/tb_top.sv */
// self-checking bench for the status flag block
`timescale 1ns/10ps
module tb_top;
   import hwmon_status_pkg::*;
   logic core_clk, srst, read, write, waitrequest, monitor_start, irq, supply_update;
   logic [7:0] address, core_reading, main_reading, q;
   logic [31:0] writedata, readdata;
   logic [63:0] tach_count;
   logic [3:0] tach_update;
   logic [1:0] diode_fault, diode_update;
   logic [15:0] diode_temp;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   // ----------------------------------------------------------------
   // device and front-end model
   // ----------------------------------------------------------------
   hwmon_status #(.fans(4)) dut_u (.core_clk(core_clk), .srst(srst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
      .waitrequest(waitrequest), .tach_count(tach_count), .tach_update(tach_update),
      .diode_fault(diode_fault), .diode_update(diode_update), .diode_temp(diode_temp),
      .core_reading(core_reading), .main_reading(main_reading), .supply_update(supply_update),
      .monitor_start(monitor_start), .irq(irq));
   front_end_model fe_u (.core_clk(core_clk), .tach_count(tach_count), .tach_update(tach_update),
      .diode_fault(diode_fault), .diode_update(diode_update), .diode_temp(diode_temp),
      .core_reading(core_reading), .main_reading(main_reading), .supply_update(supply_update));
   // clock generator
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ----------------------------------------------------------------
   // compare, bus access and closing tasks
   // ----------------------------------------------------------------
   task final_report();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one avalon transfer, held until waitrequest is sampled low
   task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      address <= a;
      writedata <= {24'h0, d};
      write <= wr;
      read <= ~wr;
      // no local limit: only the hang guard ends a wait
      do begin
         @(posedge core_clk);
      end while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr_reg
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check(q, e);
   endtask : rd_chk
   // hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      srst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0;
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      // reset values, unmapped and read-only places
      rd_chk(core_low_addr, 8'h00);
      rd_chk(core_high_addr, 8'hff);
      rd_chk(main_low_addr, 8'h00);
      rd_chk(main_high_addr, 8'hff);
      rd_chk(8'h70, read_data_unmapped);
      wr_reg(event_flags_addr, 8'hff);
      rd_chk(event_flags_addr, 8'h00);
      // limits written with the lock set, monitoring stopped
      wr_reg(control_addr, 8'h02);
      for (int i = 0; i < 4; i++) wr_reg(core_low_addr + 8'(i), (i % 2) ? 8'he0 : 8'h40);
      for (int i = 0; i < 4; i++) rd_chk(core_low_addr + 8'(i), (i % 2) ? 8'he0 : 8'h40);
      for (int i = 0; i < 8; i++) wr_reg(tach_min_base_addr + 8'(i), (i % 2) ? 8'h10 : 8'h00);
      // events while stopped set nothing
      fe_u.tach(0, 16'h1001);
      fe_u.supply(8'h00, 8'hff);
      rd_chk(event_flags_addr, 8'h00);
      rd_chk(first_status_addr, 8'h00);
      check({7'h0, monitor_start}, 8'h00);
      wr_reg(control_addr, 8'h03);
      fe_u.supply(8'hc0, 8'hc0);
      check({7'h0, monitor_start}, 8'h01);
      // each fan: above minimum sets and holds through read, at minimum read clears
      for (int i = 0; i < 4; i++) begin
         fe_u.tach(i, 16'h1001);
         rd_chk(event_flags_addr, 8'(1 << (2 + i)));
         rd_chk(first_status_addr, 8'h80);
         fe_u.tach(i, 16'h1000);
         rd_chk(event_flags_addr, 8'(1 << (2 + i)));
         rd_chk(event_flags_addr, 8'h00);
         rd_chk(first_status_addr, 8'h00);
      end
      // supply windows at their boundaries
      for (int k = 0; k < 4; k++) begin
         logic [7:0] c, m, e;
         c = (k == 1) ? 8'h40 : ((k == 3) ? 8'he0 : 8'hc0);
         m = (k == 2) ? 8'he1 : ((k == 3) ? 8'h41 : 8'hc0);
         e = (k == 1) ? 8'h02 : ((k == 2) ? 8'h04 : 8'h00);
         fe_u.supply(c, m);
         rd_chk(first_status_addr, e);
         fe_u.supply(8'hc0, 8'hc0);
         rd_chk(first_status_addr, e);
         rd_chk(first_status_addr, 8'h00);
      end
      // individual enable cleared: no set, delayed clear while stopped
      wr_reg(enable_addr, 8'hfb);
      fe_u.tach(0, 16'h1001);
      rd_chk(event_flags_addr, 8'h00);
      wr_reg(enable_addr, 8'hff);
      fe_u.tach(0, 16'h1001);
      fe_u.tach(0, 16'h1000);
      wr_reg(control_addr, 8'h02);
      wr_reg(enable_addr, 8'hfb);
      fe_u.tach(0, 16'h1000);
      rd_chk(first_status_addr, 8'h80);
      wr_reg(control_addr, 8'h03);
      fe_u.tach(0, 16'h1000);
      rd_chk(first_status_addr, 8'h00);
      wr_reg(enable_addr, 8'hff);
      // diode faults on both pairs
      for (int j = 0; j < 2; j++) begin
         fe_u.diode(j, 1'b1);
         rd_chk(event_flags_addr, 8'(1 << (6 + j)));
         rd_chk(event_flags_addr, 8'(1 << (6 + j)));
         rd_chk(diode1_temp_addr + 8'(j), diode_fault_code);
         rd_chk(first_status_addr, 8'h80 | 8'(1 << (4 + 2 * j)));
         wr_reg(enable_addr, ~8'(1 << (6 + j)));
         rd_chk(event_flags_addr, 8'h00);
         rd_chk(first_status_addr, 8'h00);
         fe_u.diode(j, 1'b0);
         wr_reg(enable_addr, 8'hff);
         rd_chk(event_flags_addr, 8'h00);
      end
      // interrupt: raise, mask, unmask, clear
      wr_reg(irq_status_addr, 8'h03);
      wr_reg(irq_mask_addr, 8'h00);
      fe_u.tach(1, 16'h1001);
      rd_chk(irq_status_addr, 8'h01);
      check({7'h0, irq}, 8'h00);
      wr_reg(irq_mask_addr, 8'h01);
      repeat (2) @(posedge core_clk);
      check({7'h0, irq}, 8'h01);
      wr_reg(irq_status_addr, 8'h01);
      repeat (2) @(posedge core_clk);
      check({7'h0, irq}, 8'h00);
      rd_chk(irq_status_addr, 8'h00);
      final_report();
   end
endmodule : tb_top
